//--- core/vms_pkg.sv
// package: register map, field positions, reset values and types for the voltage monitor
package vms_pkg;

    // register offsets
    localparam logic [7:0] VMS_ADDR_SUMMARY = 8'h12;
    localparam logic [7:0] VMS_ADDR_REF_EN = 8'h11;
    localparam logic [7:0] VMS_ADDR_CHAN_EN = 8'h13;
    localparam logic [7:0] VMS_ADDR_AVG = 8'h40;
    localparam logic [7:0] VMS_ADDR_CONV = 8'h73;
    localparam logic [7:0] VMS_ADDR_BYPASS = 8'h7D;
    localparam logic [7:0] VMS_ADDR_EXT_A = 8'h1F;
    localparam logic [7:0] VMS_ADDR_EXT_B = 8'h76;
    localparam logic [7:0] VMS_ADDR_EXT_C = 8'h77;
    // channel order: 0 link_reference_voltage, 1 2.5 V, 2 core, 3 supply, 4 5 V, 5 12 V
    localparam logic [5:0][7:0] VMS_ADDR_RESULT = {8'h24, 8'h23, 8'h22, 8'h21, 8'h20, 8'h1E};
    localparam logic [5:0][7:0] VMS_ADDR_LOW = {8'h4C, 8'h4A, 8'h48, 8'h46, 8'h44, 8'h84};
    localparam logic [5:0][7:0] VMS_ADDR_HIGH = {8'h4D, 8'h4B, 8'h49, 8'h47, 8'h45, 8'h86};
    // status banks: 0x41 0x42 0x43 0x81 0x7E 0xB6..0xBA and their masks
    localparam logic [9:0][7:0] VMS_ADDR_STAT =
        {8'hBA, 8'hB9, 8'hB8, 8'hB7, 8'hB6, 8'h7E, 8'h81, 8'h43, 8'h42, 8'h41};
    localparam logic [9:0][7:0] VMS_ADDR_MASK =
        {8'hC0, 8'hBF, 8'hBE, 8'hBD, 8'hBC, 8'h7F, 8'h83, 8'h82, 8'h75, 8'h74};

    // summary bit carried by banks 0..2 (points at the next bank)
    localparam int VMS_OOL_POS = 7;
    localparam logic [9:0] VMS_OOL_BANKS = 10'h007;
    // where each channel's out-of-limit flag lives
    localparam logic [5:0][3:0] VMS_VST_BANK = {4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h3};
    localparam logic [5:0][2:0] VMS_VST_BIT = {3'h0, 3'h3, 3'h2, 3'h1, 3'h0, 3'h6};

    // field positions
    localparam int VMS_REF_EN_POS = 2;
    localparam int VMS_AVG_OFF_POS = 3;
    localparam int VMS_AVG_SEL_LO = 6;
    localparam int VMS_SUPPLY_CH = 3;

    // reset values
    localparam logic [7:0] VMS_RESULT_RST = 8'h00;
    localparam logic [7:0] VMS_LOW_RST = 8'h00;
    localparam logic [7:0] VMS_HIGH_RST = 8'hFF;
    localparam logic [7:0] VMS_REF_EN_RST = 8'h04;
    localparam logic [7:0] VMS_CHAN_EN_RST = 8'hF8;
    localparam logic [7:0] VMS_CFG_RST = 8'h00;
    localparam logic [7:0] VMS_MASK_RST = 8'h00;

    // averaging: 4 << sel samples, shift 2 + sel
    localparam logic [2:0] VMS_AVG_MIN_SHIFT = 3'h2;

    typedef enum logic [1:0] {VMS_IDLE, VMS_START, VMS_WAIT, VMS_UPDATE} vms_fsm_t;

    typedef logic [9:0][7:0] vms_bank_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vms_reg_req_t;

    typedef struct packed {
        vms_fsm_t state;
        logic [2:0] chan;
        logic [14:0] acc;
        logic [4:0] cnt;
        logic [5:0][9:0] result;
        logic [5:0][7:0] low;
        logic [5:0][7:0] high;
        vms_bank_t stat;
        vms_bank_t mask;
        logic [7:0] ref_en;
        logic [7:0] chan_en;
        logic [7:0] avg;
        logic [7:0] conv;
        logic [7:0] bypass_cfg;
        logic [5:0] bypass;
        logic [5:0] lock;
        logic conv_start;
        logic [7:0] rdata;
        logic alert;
    } vms_state_t;

endpackage : vms_pkg

//--- core/vms_core.sv
// voltage monitor: sequencer, result/limit registers, sticky status and alert
//
// Function
// RULE_01: summary bits never drive the alert output
// RULE_02: register 0x12 summarises which status banks asserted; banks 0x43 and 0x81 do not reach it
// RULE_03: each maskable status bank has paired mask
// RULE_04: 10-bit results, nominal input reads 0x300
// RULE_05: supply channel attenuator can never be bypassed
// RULE_06: result registers at 0x1E, 0x20-0x24, reset zero
// RULE_07: extended read freezes matching result until read
// RULE_08: host reads extended register, then result register
// RULE_09: per-channel loop enables in 0x11 and 0x13
// RULE_10: disabled channels are skipped in the loop
// RULE_11: unattenuated code step is 1.953 mV, 0-2 V
// RULE_12: each channel compared against own high, low
// RULE_13: limit registers placed as documented low/high pairs
// RULE_14: averaging 4/8/16/32 samples from 0x40 bits 7:6
// RULE_15: bit 3 of 0x73 disables averaging
// RULE_16: 0x7D bits 7:3 bypass channel attenuators
// RULE_17: status bits stay set until their register read
// RULE_18: masked status bits recorded but never alert
// RULE_19: round-robin over enabled channels, update after each
`timescale 1ns/1ps
module vms_core (
    // clock, reset, enable
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // register port from the serial slave engine
    input vms_pkg::vms_reg_req_t reg_req_in,
    output logic [7:0] rdata_out,
    // converter
    output logic conv_start_out,
    output logic [2:0] conv_chan_out,
    output logic [5:0] conv_bypass_out,
    input wire logic conv_done_in,
    input wire logic [9:0] conv_data_in,
    // events from other monitors
    input vms_pkg::vms_bank_t hw_events_in,
    input wire logic therm_pending_in,
    // alert pin
    output logic alert_output_out
);

    vms_pkg::vms_state_t q;
    vms_pkg::vms_state_t d;

    logic [5:0] chan_en;
    logic [2:0] avg_shift;
    logic [4:0] avg_target;
    logic [9:0] avg_val;
    logic [7:0] res8;
    logic out_of_range;
    logic [7:0] summary;
    logic [7:0] rd_val;
    vms_pkg::vms_bank_t bank_view;
    vms_pkg::vms_bank_t stat_set;
    logic [9:0] stat_read;
    logic [9:0] alert_bank;
    logic [2:0] next_chan;
    logic next_found;

    // per-bank read view, alert gating and read-clear strobes
    for (genvar b = 0; b < 10; b++) begin : g_bank
        logic [7:0] pend;
        if (vms_pkg::VMS_OOL_BANKS[b]) begin : g_ool
            // summary bit is live: set while the next bank holds anything
            assign pend = {|q.stat[b + 1], q.stat[b][6:0]}; // see RULE_02
        end else begin : g_plain
            assign pend = q.stat[b];
        end
        assign bank_view[b] = pend;
        // summary bits are not in q.stat, so they cannot reach the pin
        assign alert_bank[b] = |(q.stat[b] & ~q.mask[b]); // see RULE_01 see RULE_18
        assign stat_read[b] = reg_req_in.rd && reg_req_in.addr == vms_pkg::VMS_ADDR_STAT[b];
    end

    // summary register 0x12
    assign summary = {therm_pending_in, |q.stat[9], |q.stat[8], |q.stat[7], |q.stat[6],
                      |q.stat[5], |q.stat[4], |bank_view[0]}; // see RULE_02

    // channel enables in loop order
    assign chan_en = {q.chan_en[3], q.chan_en[4], q.chan_en[7], q.chan_en[5], q.chan_en[6],
                      q.ref_en[vms_pkg::VMS_REF_EN_POS]}; // see RULE_09

    // averaging length; averaging off trades noise for loop speed
    always_comb begin
        if (q.conv[vms_pkg::VMS_AVG_OFF_POS]) begin // see RULE_15
            avg_shift = 3'h0;
            avg_target = 5'h00;
        end else begin
            avg_shift = vms_pkg::VMS_AVG_MIN_SHIFT + {1'b0, q.avg[vms_pkg::VMS_AVG_SEL_LO +: 2]};
            avg_target = 5'((6'h04 << q.avg[vms_pkg::VMS_AVG_SEL_LO +: 2]) - 6'h01); // see RULE_14
        end
    end

    // full 10-bit code kept; 0x300 is the nominal point, step 1.953 mV unattenuated
    assign avg_val = 10'(q.acc >> avg_shift); // see RULE_04 see RULE_11
    assign res8 = avg_val[9:2];
    assign out_of_range = (res8 > q.high[q.chan]) || (res8 < q.low[q.chan]); // see RULE_12

    // next enabled channel after the current one
    always_comb begin
        int idx;
        idx = 0;
        next_found = 1'b0;
        next_chan = q.chan;
        for (int k = 1; k <= 6; k++) begin
            idx = (int'(q.chan) + k) % 6;
            if (!next_found && chan_en[idx]) begin // see RULE_10
                next_found = 1'b1;
                next_chan = 3'(idx);
            end
        end
    end

    // register read mux
    always_comb begin
        rd_val = 8'h00;
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_SUMMARY) rd_val = summary;
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_REF_EN) rd_val = q.ref_en;
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_CHAN_EN) rd_val = q.chan_en;
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_AVG) rd_val = q.avg;
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_CONV) rd_val = q.conv;
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_BYPASS) rd_val = q.bypass_cfg;
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_EXT_A) rd_val = {6'h00, q.result[0][1:0]};
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_EXT_B) begin
            rd_val = {q.result[4][1:0], q.result[3][1:0], q.result[2][1:0], q.result[1][1:0]};
        end
        if (reg_req_in.addr == vms_pkg::VMS_ADDR_EXT_C) rd_val = {6'h00, q.result[5][1:0]};
        for (int c = 0; c < 6; c++) begin
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_RESULT[c]) rd_val = q.result[c][9:2];
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_LOW[c]) rd_val = q.low[c];
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_HIGH[c]) rd_val = q.high[c];
        end
        for (int b = 0; b < 10; b++) begin
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_STAT[b]) rd_val = bank_view[b];
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_MASK[b]) rd_val = q.mask[b];
        end
    end

    // next state
    always_comb begin
        d = q;
        stat_set = hw_events_in;
        for (int b = 0; b < 10; b++) begin
            if (vms_pkg::VMS_OOL_BANKS[b]) stat_set[b][vms_pkg::VMS_OOL_POS] = 1'b0;
        end
        d.conv_start = 1'b0;

        // converter sequencer
        case (q.state)
            vms_pkg::VMS_IDLE: begin
                if (next_found) begin // see RULE_19
                    d.chan = next_chan;
                    d.acc = 15'h0000;
                    d.cnt = 5'h00;
                    d.conv_start = 1'b1;
                    d.state = vms_pkg::VMS_WAIT;
                end
            end
            vms_pkg::VMS_START: begin
                d.conv_start = 1'b1;
                d.state = vms_pkg::VMS_WAIT;
            end
            vms_pkg::VMS_WAIT: begin
                if (conv_done_in) begin
                    d.acc = q.acc + {5'h00, conv_data_in};
                    if (q.cnt >= avg_target) begin
                        d.state = vms_pkg::VMS_UPDATE;
                    end else begin
                        d.cnt = q.cnt + 5'h01;
                        d.state = vms_pkg::VMS_START;
                    end
                end
            end
            vms_pkg::VMS_UPDATE: begin
                // a frozen result keeps its pair intact for the host
                if (!q.lock[q.chan]) d.result[q.chan] = avg_val; // see RULE_07 see RULE_08
                if (out_of_range) begin
                    stat_set[vms_pkg::VMS_VST_BANK[q.chan]][vms_pkg::VMS_VST_BIT[q.chan]] = 1'b1; // see RULE_12
                end
                d.state = vms_pkg::VMS_IDLE;
            end
            default: d.state = vms_pkg::VMS_IDLE;
        endcase

        // sticky status, cleared by a read; a new event in the same cycle wins
        for (int b = 0; b < 10; b++) begin
            d.stat[b] = (stat_read[b] ? 8'h00 : q.stat[b]) | stat_set[b]; // see RULE_17
        end

        // result freezing on extended reads, release on result reads
        if (reg_req_in.rd) begin
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_EXT_A) d.lock[0] = 1'b1; // see RULE_07
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_EXT_B) d.lock[4:1] = 4'hF;
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_EXT_C) d.lock[5] = 1'b1;
            for (int c = 0; c < 6; c++) begin
                if (reg_req_in.addr == vms_pkg::VMS_ADDR_RESULT[c]) d.lock[c] = 1'b0;
            end
            d.rdata = rd_val;
        end

        // register writes
        if (reg_req_in.wr) begin
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_REF_EN) d.ref_en = reg_req_in.wdata;
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_CHAN_EN) d.chan_en = reg_req_in.wdata;
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_AVG) d.avg = reg_req_in.wdata;
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_CONV) d.conv = reg_req_in.wdata;
            if (reg_req_in.addr == vms_pkg::VMS_ADDR_BYPASS) d.bypass_cfg = reg_req_in.wdata;
            for (int c = 0; c < 6; c++) begin
                if (reg_req_in.addr == vms_pkg::VMS_ADDR_LOW[c]) begin
                    d.low[c] = reg_req_in.wdata; // see RULE_13
                end
                if (reg_req_in.addr == vms_pkg::VMS_ADDR_HIGH[c]) d.high[c] = reg_req_in.wdata;
            end
            for (int b = 0; b < 10; b++) begin
                if (reg_req_in.addr == vms_pkg::VMS_ADDR_MASK[b]) begin
                    d.mask[b] = reg_req_in.wdata; // see RULE_03
                end
            end
        end

        // attenuator bypass; supply channel has no bypass path
        d.bypass = {d.bypass_cfg[7], d.bypass_cfg[6], 1'b0, d.bypass_cfg[5], d.bypass_cfg[4],
                    d.bypass_cfg[3]}; // see RULE_16 see RULE_05
        d.alert = |alert_bank; // see RULE_18
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
            q.state <= vms_pkg::VMS_IDLE;
            q.result <= {6{vms_pkg::VMS_RESULT_RST, 2'b00}}; // see RULE_06
            q.low <= {6{vms_pkg::VMS_LOW_RST}};
            q.high <= {6{vms_pkg::VMS_HIGH_RST}};
            q.mask <= {10{vms_pkg::VMS_MASK_RST}};
            q.ref_en <= vms_pkg::VMS_REF_EN_RST;
            q.chan_en <= vms_pkg::VMS_CHAN_EN_RST;
            q.avg <= vms_pkg::VMS_CFG_RST;
            q.conv <= vms_pkg::VMS_CFG_RST;
            q.bypass_cfg <= vms_pkg::VMS_CFG_RST;
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign rdata_out = q.rdata;
    assign conv_start_out = q.conv_start;
    assign conv_chan_out = q.chan;
    assign conv_bypass_out = q.bypass;
    assign alert_output_out = q.alert;

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    logic [1:0] mask_full_cnt;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) mask_full_cnt <= 2'h0;
        else if ((q.stat & ~q.mask) != '0) mask_full_cnt <= 2'h0;
        else if (mask_full_cnt != 2'h3) mask_full_cnt <= mask_full_cnt + 2'h1;
    end

    AST_MASKED_SILENT: assert property (mask_full_cnt == 2'h3 |-> !alert_output_out) // see RULE_18
        else $error("alert raised with only masked status bits set");
    AST_SUPPLY_ATTEN: assert property (!conv_bypass_out[vms_pkg::VMS_SUPPLY_CH]) // see RULE_05
        else $error("supply attenuator bypassed");
    // an enable write landing on the launch edge is not the sequencer's fault,
    // so only the first start of a visit with steady enables is judged
    AST_SKIP_DISABLED: assert property (conv_start_out && q.cnt == 5'h00 // see RULE_10
        && $stable(chan_en) |-> chan_en[conv_chan_out])
        else $error("conversion started on excluded channel");
    AST_SUMMARY_BANK: assert property (ce_in && reg_req_in.rd // see RULE_02
        && reg_req_in.addr == vms_pkg::VMS_ADDR_SUMMARY && q.stat[5] != 8'h00 |=> rdata_out[2])
        else $error("summary missed bank assertion");
    AST_RESULT_READ: assert property (ce_in && reg_req_in.rd // see RULE_06
        && reg_req_in.addr == vms_pkg::VMS_ADDR_RESULT[1] |=> rdata_out == $past(q.result[1][9:2]))
        else $error("result register read wrong value");
    AST_LOCK_HOLD: assert property (q.lock[2] && !(reg_req_in.rd // see RULE_07
        && reg_req_in.addr == vms_pkg::VMS_ADDR_RESULT[2]) |=> $stable(q.result[2]))
        else $error("locked result changed");
    AST_STICKY: assert property (!stat_read[0] |=> (q.stat[0] & $past(q.stat[0])) // see RULE_17
        == $past(q.stat[0]))
        else $error("status bit dropped without a read");
    AST_LIMIT_FLAG: assert property (ce_in && q.state == vms_pkg::VMS_UPDATE // see RULE_12
        && q.chan == 3'h3 && out_of_range |=> q.stat[0][2])
        else $error("out-of-limit not flagged");
    // the length may be rewritten mid-visit, so judge each sample against the live length
    AST_AVG_BOUND: assert property (ce_in && q.state == vms_pkg::VMS_WAIT // see RULE_14
        && conv_done_in && q.cnt >= avg_target |=> q.state == vms_pkg::VMS_UPDATE)
        else $error("sample count beyond averaging length");
    AST_AVG_MORE: assert property (ce_in && q.state == vms_pkg::VMS_WAIT // see RULE_14
        && conv_done_in && q.cnt < avg_target |=> q.state == vms_pkg::VMS_START)
        else $error("averaging stopped early");
    AST_EXT_LOCK: assert property (ce_in && reg_req_in.rd // see RULE_07
        && reg_req_in.addr == vms_pkg::VMS_ADDR_EXT_B |=> q.lock[4:1] == 4'hF)
        else $error("extended read did not freeze results");
    AST_UNLOCK: assert property (ce_in && reg_req_in.rd // see RULE_07
        && reg_req_in.addr == vms_pkg::VMS_ADDR_RESULT[1] |=> !q.lock[1])
        else $error("result read left its channel frozen");
    AST_READ_CLEAR: assert property (ce_in && stat_read[5] // see RULE_17
        && hw_events_in[5] == 8'h00 |=> q.stat[5] == 8'h00)
        else $error("status bank not cleared by its read");
    AST_SINGLE_SAMPLE: assert property (ce_in && q.conv[vms_pkg::VMS_AVG_OFF_POS] // see RULE_15
        && q.state == vms_pkg::VMS_WAIT && conv_done_in |=> q.state == vms_pkg::VMS_UPDATE)
        else $error("averaging ran while disabled");

    COV_ALERT: cover property (!alert_output_out ##1 alert_output_out);
    COV_LOCK_PAIR: cover property (q.lock[0] ##[1:20] !q.lock[0]);
    COV_WRAP: cover property (q.state == vms_pkg::VMS_UPDATE && q.chan == 3'h5 ##1 q.chan == 3'h0);
    COV_AVG_LONG: cover property (q.state == vms_pkg::VMS_UPDATE && q.cnt == 5'h1F);
    COV_MASKED: cover property ((q.stat[0] & q.mask[0]) != 8'h00);

endmodule : vms_core

//--- test/vms_adc_model.sv
// converter model: one done pulse per start, after a delay chosen by the bench
`timescale 1ns/1ps
module vms_adc_model (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // from the block
    input wire logic start_in,
    input wire logic [2:0] chan_in,
    // bench controls
    input wire logic [3:0] delay_in,
    input wire logic wobble_in,
    input wire logic [5:0][9:0] codes_in,
    // answer
    output logic done_out,
    output logic [9:0] data_out
);
    logic [4:0] cnt_q;
    logic odd_q;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= 5'h00;
            odd_q <= 1'b0;
            done_out <= 1'b0;
            data_out <= 10'h000;
        end else begin
            done_out <= 1'b0;
            // a stale code must not pass for a fresh one between answers
            data_out <= ~data_out;
            if (start_in) begin
                cnt_q <= {1'b0, delay_in} + 5'h01;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
                if (cnt_q == 5'h01) begin
                    done_out <= 1'b1;
                    odd_q <= ~odd_q;
                    data_out <= codes_in[chan_in] + ((wobble_in && odd_q) ? 10'h004 : 10'h000);
                end
            end
        end
    end
endmodule : vms_adc_model

//--- test/voltage_monitor_status_control_bench.sv
// bench for the voltage monitor core: register tasks, converter model and checks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module voltage_monitor_status_control_bench;
    logic clock_in, rstn_in, start, done, wob, therm, alert, clr;
    vms_pkg::vms_reg_req_t req;
    vms_pkg::vms_bank_t ev;
    logic [7:0] rdata;
    logic [2:0] chan, last_chan;
    logic [5:0] byp, seen, cur_run;
    logic [9:0] data;
    logic [3:0] delay;
    logic [5:0][9:0] codes;
    logic [5:0][5:0] run;
    int n_fail, tests_run;
    vms_core DUT (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(1'b1), .reg_req_in(req),
        .rdata_out(rdata), .conv_start_out(start), .conv_chan_out(chan),
        .conv_bypass_out(byp), .conv_done_in(done), .conv_data_in(data),
        .hw_events_in(ev), .therm_pending_in(therm), .alert_output_out(alert));
    vms_adc_model ADC (.clock_in(clock_in), .rstn_in(rstn_in), .start_in(start),
        .chan_in(chan), .delay_in(delay), .wobble_in(wob), .codes_in(codes),
        .done_out(done), .data_out(data));
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    // a visit counts as finished once the next channel starts
    always @(posedge clock_in) begin
        if (start && chan != last_chan) begin
            run[last_chan] <= cur_run;
            seen[last_chan] <= 1'b1;
            cur_run <= 6'h01;
            last_chan <= chan;
        end else if (start) begin
            cur_run <= cur_run + 6'h01;
        end
        // the clear wins over a start on the same edge, so the visit that start ends is not marked seen
        if (clr) begin
            seen <= 6'h00;
        end
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clock_in);
        req.rd <= 1'b0;
        @(posedge clock_in);
        d = rdata;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clock_in);
        req.wr <= 1'b0;
        @(posedge clock_in);
    endtask : wr
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK("register", e, d)
    endtask : chk_rd
    // two full passes, so the second sees only settings already in force
    task automatic loops(input logic [5:0] want);
        int i;
        for (int k = 0; k < 2; k++) begin
            clr <= 1'b1;
            @(posedge clock_in);
            clr <= 1'b0;
            @(posedge clock_in);
            for (i = 0; i < 20000 && (seen & want) != want; i++) @(posedge clock_in);
            if (i == 20000) begin
                n_fail++;
                close_out();
            end
        end
        repeat (3) @(posedge clock_in);
    endtask : loops
    task automatic pulse(input int b);
        ev[b] <= 8'h01;
        @(posedge clock_in);
        ev[b] <= 8'h00;
        repeat (2) @(posedge clock_in);
    endtask : pulse
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    initial begin
        rstn_in = 1'b0;
        req = '0;
        ev = '0;
        therm = 1'b0;
        clr = 1'b0;
        wob = 1'b0;
        delay = 4'h2;
        codes = '0;
        seen = '0;
        run = '0;
        cur_run = '0;
        last_chan = 3'h0;
        repeat (12) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        for (int c = 0; c < 6; c++) chk_rd(vms_pkg::VMS_ADDR_RESULT[c], 8'h00);
        chk_rd(8'h11, 8'h04);
        chk_rd(8'h13, 8'hF8);
        chk_rd(8'h4D, 8'hFF);
        chk_rd(8'h05, 8'h00);
        codes <= {10'h004, 10'h3FC, 10'h302, 10'h100, 10'h301, 10'h040};
        wr(8'h73, 8'h08);
        loops(6'h3F);
        for (int c = 0; c < 6; c++) chk_rd(vms_pkg::VMS_ADDR_RESULT[c], codes[c][9:2]);
        // slow converter and alternating codes: each average but channel 4's lands two codes up, as its raised code wraps to 0
        delay <= 4'h7;
        wob <= 1'b1;
        wr(8'h73, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(8'h40, 8'(s << 6));
            loops(6'h3F);
            `CHK("visit length", 6'(4 << s), run[1])
            chk_rd(8'h22, 8'hC1);
        end
        wob <= 1'b0;
        delay <= 4'h0;
        wr(8'h73, 8'h08);
        wr(8'h13, 8'hE8);
        wr(8'h11, 8'h00);
        loops(6'h2E);
        `CHK("channels visited", 6'h2E, seen)
        wr(8'h11, 8'h04);
        wr(8'h13, 8'hF8);
        wr(8'h7D, 8'hF8);
        loops(6'h3F);
        `CHK("bypass", 6'h37, byp)
        wr(8'h7D, 8'h00);
        chk_rd(8'h76, 8'h21);
        codes[1] <= 10'h200;
        loops(6'h3F);
        chk_rd(8'h20, 8'hC0);
        loops(6'h3F);
        chk_rd(8'h20, 8'h80);
        wr(8'h49, 8'h80);
        loops(6'h3F);
        `CHK("alert", 1'b1, alert)
        chk_rd(8'h12, 8'h01);
        wr(8'h49, 8'hFF);
        loops(6'h3F);
        chk_rd(8'h41, 8'h04);
        chk_rd(8'h41, 8'h00);
        repeat (2) @(posedge clock_in);
        `CHK("alert", 1'b0, alert)
        wr(8'h4C, 8'h02);
        loops(6'h3F);
        wr(8'h4C, 8'h00);
        loops(6'h3F);
        chk_rd(8'h41, 8'h80);
        chk_rd(8'h42, 8'h01);
        chk_rd(8'h41, 8'h00);
        wr(8'h74, 8'h04);
        wr(8'h49, 8'h80);
        loops(6'h3F);
        `CHK("alert", 1'b0, alert)
        wr(8'h49, 8'hFF);
        loops(6'h3F);
        chk_rd(8'h41, 8'h04);
        wr(8'h74, 8'h00);
        for (int b = 5; b < 10; b++) begin
            pulse(b);
            chk_rd(8'h12, 8'(1 << (b - 3)));
            `CHK("alert", 1'b1, alert)
            chk_rd(vms_pkg::VMS_ADDR_STAT[b], 8'h01);
            wr(vms_pkg::VMS_ADDR_MASK[b], 8'h01);
            pulse(b);
            chk_rd(vms_pkg::VMS_ADDR_STAT[b], 8'h01);
            repeat (2) @(posedge clock_in);
            `CHK("alert", 1'b0, alert)
        end
        therm <= 1'b1;
        chk_rd(8'h12, 8'h80);
        `CHK("alert", 1'b0, alert)
        therm <= 1'b0;
        close_out();
    end
endmodule : voltage_monitor_status_control_bench
